/* hdl/hbp_pkg.sv */
// constants and types shared by the host bus port
package hbp_pkg;

  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int AD_W = 16;
  localparam int CLK_PERIOD_NS = 20;
  localparam int IACK_READY_NS = 60;
  localparam int IACK_READY_CYC =
    (IACK_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam int REG_IDX_W = 3;
  localparam int BYTE_BIT = 15;
  localparam int SYNC_LAT = 2;

  // ------------------------------------------------------------
  // register indices and fields
  // ------------------------------------------------------------
  localparam logic [REG_IDX_W-1:0] A_BCR = 3'h0;
  localparam logic [REG_IDX_W-1:0] A_PEND = 3'h1;
  localparam logic [REG_IDX_W-1:0] A_EN = 3'h2;
  localparam logic [REG_IDX_W-1:0] A_US = 3'h3;
  localparam logic [REG_IDX_W-1:0] A_VEC = 3'h4;
  localparam logic [REG_IDX_W-1:0] A_STAT = 3'h5;
  localparam int BCR_ACK_LO = 0;
  localparam int BCR_ACK_HI = 1;
  localparam int BCR_IRQ_OD = 2;
  localparam int BCR_BYTE = 3;
  localparam logic [AD_W-1:0] BCR_RST = 16'h0000;
  localparam logic [AD_W-1:0] VEC_RST = 16'h0000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ACK_STATUS = 2'b00,
    ACK_PULSE = 2'b01,
    ACK_DOUBLE = 2'b10
  } hbp_ack_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ADDR = 3'b001,
    M_SETUP = 3'b010,
    M_STRB = 3'b011,
    M_HOLD = 3'b100
  } hbp_mst_e;

endpackage

/* hdl/hbp_sync.sv */
// two flip-flop synchroniser for a vector of pin inputs
module hbp_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* hdl/hbp_prio.sv */
// finds the highest-priority enabled pending source, index 0 highest
module hbp_prio #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] us,
  output logic any,
  output logic [IW-1:0] idx,
  output logic blocked
);

  always_comb begin
    logic us_seen;
    us_seen = 1'b0;
    any = 1'b0;
    idx = '0;
    blocked = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (!any) begin
        us_seen = us_seen | us[i];
        if (req[i]) begin
          any = 1'b1;
          idx = IW'(i);
          blocked = us_seen;
        end
      end
    end
  end

endmodule

/* hdl/hbp_host_port.sv */
// host bus port: slave registers, dma master cycles, interrupt chain
// Operation
// - reset gives idle state; first selected write loads bus config reg
// - address strobe seen up to config write selects multiplexed bus
// - bus and dma logic run on the system clock
// - address/data bus serves slave register cycles and master cycles
// - unit select ignored while interrupt acknowledge is low
// - select latched at address strobe rise, else at strobe fall
// - read strobe output as master; master read data taken at its rise
// - slave read data driven after strobe falls, held past its rise
// - write strobe output as master; slave write taken at its rise
// - master write data valid before strobe falls until after it rises
// - master drives byte/word high for byte, low for word
// - slave size from address line at strobe rise or config bit
// - handshake pin input as master, output as slave, style at config
// - wait style: master waits while low; low until ack ready only
// - ack style: master waits for low; low for accesses, totem pole
// - request only with chain in high and an unblocked pending source
// - request pin totem pole or open drain under software control
// - config field picks status, single or double pulse acknowledge
// - acknowledge with chain in high and request: hold chain out low
// - chain out low for chain in low, under service, or requesting during acknowledge
//
// The register offsets and the plain strobed port are this design's own decisions.
module hbp_host_port
  import hbp_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int IDX_W = 3
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [AD_W-1:0] addr_data_in,
  output logic [AD_W-1:0] addr_data_out,
  output logic addr_data_oe_n,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic cs_n,
  input wire logic rd_n_in,
  output logic rd_n_out,
  output logic rd_n_oe_n,
  input wire logic wr_n_in,
  output logic wr_n_out,
  output logic wr_n_oe_n,
  output logic byte_word_out,
  output logic byte_word_oe_n,
  input wire logic wait_ack_in,
  output logic wait_ack_out,
  output logic wait_ack_oe_n,
  input wire logic hs_style_sel,
  output logic irq_req_n,
  output logic irq_req_oe_n,
  input wire logic irq_ack_n,
  input wire logic irq_chain_in,
  output logic irq_chain_out,
  input wire logic [NSRC-1:0] irq_events,
  output logic [AD_W-1:0] ext_addr,
  output logic [AD_W-1:0] ext_wdata,
  output logic ext_wr,
  output logic ext_rd,
  output logic ext_byte,
  input wire logic [AD_W-1:0] ext_rdata,
  input wire logic mst_grant,
  input wire logic mst_req,
  input wire logic mst_write,
  input wire logic mst_byte,
  input wire logic [AD_W-1:0] mst_addr,
  input wire logic [AD_W-1:0] mst_wdata,
  output logic [AD_W-1:0] mst_rdata,
  output logic mst_done,
  output logic mst_busy
);

  // ------------------------------------------------------------
  // pin synchronisers and edges
  // ------------------------------------------------------------
  logic [AD_W+8:0] syn;
  logic [AD_W-1:0] ad_s;
  logic as_s, ds_s, cs_s, rd_s, wr_s, iack_s, iei_s, sel_s, wait_s;
  logic as_p, ds_p, rd_p, wr_p, iack_p;

  hbp_sync #(.W(AD_W + 9), .RST({{AD_W{1'b0}}, 9'h1f9})) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .d({addr_data_in, addr_strobe_n, data_strobe_n, cs_n, rd_n_in,
        wr_n_in, irq_ack_n, irq_chain_in, hs_style_sel, wait_ack_in}),
    .q(syn)
  );

  assign {ad_s, as_s, ds_s, cs_s, rd_s, wr_s, iack_s, iei_s, sel_s,
          wait_s} = syn;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      as_p <= 1'b1;
      ds_p <= 1'b1;
      rd_p <= 1'b1;
      wr_p <= 1'b1;
      iack_p <= 1'b1;
    end else begin
      as_p <= as_s;
      ds_p <= ds_s;
      rd_p <= rd_s;
      wr_p <= wr_s;
      iack_p <= iack_s;
    end
  end

  hbp_mst_e m_state, m_next;
  logic own;
  logic as_rise, as_fall, ds_fall, rd_fall, rd_rise, wr_fall, wr_rise;
  logic iack_fall, iack_rise;

  assign own = (m_state != M_IDLE);
  assign as_rise = as_s & ~as_p;
  assign as_fall = ~as_s & as_p;
  assign ds_fall = ~ds_s & ds_p;
  assign rd_fall = ~rd_s & rd_p & ~own;
  assign rd_rise = rd_s & ~rd_p & ~own;
  assign wr_fall = ~wr_s & wr_p & ~own;
  assign wr_rise = wr_s & ~wr_p & ~own;
  assign iack_fall = ~iack_s & iack_p;
  assign iack_rise = iack_s & ~iack_p;

  // ------------------------------------------------------------
  // bus mode, select and address latch
  // ------------------------------------------------------------
  logic mux_q, cfg_done_q, style_q, cs_lat_q, byte_q;
  logic [AD_W-1:0] addr_q, bcr_q;
  logic cs_eff, sel_now, byte_eff;

  assign cs_eff = cs_s | ~iack_s;
  assign sel_now = mux_q ? ~cs_lat_q : ~cs_eff;
  assign byte_eff = mux_q ? byte_q : bcr_q[BCR_BYTE];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_q <= 1'b0;
      cs_lat_q <= 1'b1;
      addr_q <= '0;
      byte_q <= 1'b0;
    end else begin
      if (!cfg_done_q && as_fall) begin
        mux_q <= 1'b1;
      end
      if (mux_q && as_rise) begin
        cs_lat_q <= cs_eff;
      end else if (!mux_q && (ds_fall || rd_fall || wr_fall)) begin
        cs_lat_q <= cs_eff;
      end
      if (as_rise) begin
        addr_q <= ad_s;
        byte_q <= ad_s[BYTE_BIT];
      end
    end
  end

  function automatic logic is_local(input logic [AD_W-1:0] a);
    return (a[AD_W-1:REG_IDX_W] == '0) && (a[REG_IDX_W-1:0] <= A_STAT);
  endfunction

  // ------------------------------------------------------------
  // slave cycles
  // ------------------------------------------------------------
  logic rd_act_q, wr_act_q, rdp_q, slv_rd_start, wr_commit, loc;

  assign loc = is_local(addr_q);
  assign slv_rd_start = rd_fall & sel_now;
  assign wr_commit = wr_rise & wr_act_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      rdp_q <= 1'b0;
    end else begin
      rdp_q <= slv_rd_start;
      if (slv_rd_start) begin
        rd_act_q <= 1'b1;
      end else if (rd_rise) begin
        rd_act_q <= 1'b0;
      end
      if (wr_fall && sel_now) begin
        wr_act_q <= 1'b1;
      end else if (wr_rise) begin
        wr_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_addr <= '0;
      ext_wdata <= '0;
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
      ext_byte <= 1'b0;
    end else begin
      ext_addr <= addr_q;
      ext_wdata <= ad_s;
      ext_byte <= byte_eff;
      ext_wr <= wr_commit & cfg_done_q & ~loc;
      ext_rd <= slv_rd_start & ~loc;
    end
  end

  // ------------------------------------------------------------
  // local registers
  // ------------------------------------------------------------
  logic [NSRC-1:0] pend_q, en_q, us_q, pend_clr, us_clr, us_set;
  logic [AD_W-1:0] vec_q;
  logic loc_wr;

  assign loc_wr = wr_commit & cfg_done_q & loc;
  assign pend_clr = (loc_wr && addr_q[REG_IDX_W-1:0] == A_PEND) ?
                    ad_s[NSRC-1:0] : '0;
  assign us_clr = (loc_wr && addr_q[REG_IDX_W-1:0] == A_US) ?
                  ad_s[NSRC-1:0] : '0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bcr_q <= BCR_RST;
      style_q <= 1'b1;
      cfg_done_q <= 1'b0;
    end else if (wr_commit) begin
      if (!cfg_done_q) begin
        bcr_q <= ad_s;
        style_q <= sel_s;
        cfg_done_q <= 1'b1;
      end else if (loc && addr_q[REG_IDX_W-1:0] == A_BCR) begin
        bcr_q <= ad_s;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= '0;
      vec_q <= VEC_RST;
    end else if (loc_wr) begin
      if (addr_q[REG_IDX_W-1:0] == A_EN) begin
        en_q <= ad_s[NSRC-1:0];
      end else if (addr_q[REG_IDX_W-1:0] == A_VEC) begin
        vec_q <= ad_s;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
      us_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | irq_events;
      us_q <= (us_q & ~us_clr) | us_set;
    end
  end

  // ------------------------------------------------------------
  // interrupt request and acknowledge
  // ------------------------------------------------------------
  logic p_any, p_blk, intr_ok, ack_start, ack_end, iack_ready;
  logic [IDX_W-1:0] p_idx, resp_idx_q;
  logic ack_cyc_q, arm_q, req_seen_q, respond_q, irq_q;
  logic [CNT_W-1:0] cnt_q;
  hbp_ack_e ack_mode;

  hbp_prio #(.N(NSRC), .IW(IDX_W)) u_prio (
    .req(pend_q & en_q),
    .us(us_q),
    .any(p_any),
    .idx(p_idx),
    .blocked(p_blk)
  );

  assign intr_ok = p_any & ~p_blk;
  assign ack_mode = hbp_ack_e'(bcr_q[BCR_ACK_HI:BCR_ACK_LO]);
  assign iack_ready = (cnt_q == CNT_W'(IACK_READY_CYC));
  assign us_set = (ack_start && iei_s && intr_ok) ?
                  NSRC'(1) << p_idx : '0;

  always_comb begin
    case (ack_mode)
      ACK_PULSE: begin
        ack_start = iack_fall;
        ack_end = iack_rise;
      end
      ACK_DOUBLE: begin
        ack_start = iack_fall & arm_q;
        ack_end = iack_rise;
      end
      default: begin
        ack_start = ~ack_cyc_q & ~iack_s & (as_fall | ds_fall | rd_fall);
        ack_end = iack_s;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_cyc_q <= 1'b0;
      arm_q <= 1'b0;
      req_seen_q <= 1'b0;
      respond_q <= 1'b0;
      resp_idx_q <= '0;
      cnt_q <= '0;
    end else if (ack_start) begin
      ack_cyc_q <= 1'b1;
      req_seen_q <= irq_q;
      respond_q <= iei_s & intr_ok;
      resp_idx_q <= p_idx;
      cnt_q <= '0;
    end else if (ack_cyc_q && ack_end) begin
      ack_cyc_q <= 1'b0;
      arm_q <= 1'b0;
      req_seen_q <= 1'b0;
      respond_q <= 1'b0;
    end else begin
      if (ack_mode == ACK_DOUBLE && iack_rise && !ack_cyc_q) begin
        arm_q <= 1'b1;
      end
      if (ack_cyc_q && !iack_ready) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
      irq_req_n <= 1'b1;
      irq_req_oe_n <= 1'b0;
      irq_chain_out <= 1'b0;
    end else begin
      irq_q <= iei_s & intr_ok & ~ack_cyc_q;
      irq_req_n <= bcr_q[BCR_IRQ_OD] ? 1'b0 : ~irq_q;
      irq_req_oe_n <= bcr_q[BCR_IRQ_OD] ? ~irq_q : 1'b0;
      irq_chain_out <= iei_s & ~(|us_q) &
        ~(ack_cyc_q & (irq_q | req_seen_q | respond_q));
    end
  end

  // ------------------------------------------------------------
  // master cycles
  // ------------------------------------------------------------
  logic done_ok, slave_busy;
  logic [1:0] stb_q;

  assign done_ok = style_q ? wait_s : ~wait_s;
  assign slave_busy = rd_act_q | wr_act_q | ack_cyc_q;
  assign mst_busy = own;

  // strobe age, lets the synchronised handshake catch up
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_q <= '0;
    end else if (m_state != M_STRB) begin
      stb_q <= '0;
    end else if (stb_q != 2'(SYNC_LAT)) begin
      stb_q <= stb_q + 2'(1);
    end
  end

  always_comb begin
    m_next = m_state;
    case (m_state)
      M_IDLE: begin
        if (mst_req && mst_grant && cfg_done_q && !slave_busy) begin
          m_next = M_ADDR;
        end
      end
      M_ADDR: m_next = M_SETUP;
      M_SETUP: m_next = M_STRB;
      M_STRB: begin
        if (done_ok && stb_q == 2'(SYNC_LAT)) begin
          m_next = M_HOLD;
        end
      end
      default: m_next = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      m_state <= M_IDLE;
      mst_done <= 1'b0;
      mst_rdata <= '0;
    end else begin
      m_state <= m_next;
      mst_done <= (m_state == M_HOLD);
      if (m_state == M_HOLD && !mst_write) begin
        mst_rdata <= ad_s;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      rd_n_oe_n <= 1'b1;
      wr_n_oe_n <= 1'b1;
      byte_word_out <= 1'b0;
      byte_word_oe_n <= 1'b1;
    end else begin
      rd_n_out <= ~(m_next == M_STRB && !mst_write);
      wr_n_out <= ~(m_next == M_STRB && mst_write);
      rd_n_oe_n <= (m_next == M_IDLE);
      wr_n_oe_n <= (m_next == M_IDLE);
      byte_word_out <= mst_byte;
      byte_word_oe_n <= (m_next == M_IDLE);
    end
  end

  // ------------------------------------------------------------
  // address/data and handshake drive
  // ------------------------------------------------------------
  logic [AD_W-1:0] ad_d, loc_rdata;
  logic ad_oe_n_d;

  always_comb begin
    case (addr_q[REG_IDX_W-1:0])
      A_BCR: loc_rdata = bcr_q;
      A_PEND: loc_rdata = AD_W'(pend_q);
      A_EN: loc_rdata = AD_W'(en_q);
      A_US: loc_rdata = AD_W'(us_q);
      A_VEC: loc_rdata = vec_q;
      A_STAT: loc_rdata = AD_W'({own, style_q, mux_q, cfg_done_q});
      default: loc_rdata = '0;
    endcase
  end

  always_comb begin
    ad_d = addr_data_out;
    ad_oe_n_d = 1'b1;
    if (m_next == M_ADDR) begin
      ad_d = mst_addr;
      ad_oe_n_d = 1'b0;
    end else if (m_next != M_IDLE) begin
      if (mst_write) begin
        ad_d = mst_wdata;
        ad_oe_n_d = 1'b0;
      end
    end else if (ack_cyc_q && respond_q && iack_ready) begin
      ad_d = {vec_q[AD_W-1:IDX_W], resp_idx_q};
      ad_oe_n_d = 1'b0;
    end else if (rd_act_q) begin
      if (rdp_q) begin
        ad_d = loc ? loc_rdata : ext_rdata;
      end
      ad_oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_data_out <= '0;
      addr_data_oe_n <= 1'b1;
      wait_ack_out <= 1'b1;
      wait_ack_oe_n <= 1'b1;
    end else begin
      addr_data_out <= ad_d;
      addr_data_oe_n <= ad_oe_n_d;
      if (own) begin
        wait_ack_out <= 1'b1;
        wait_ack_oe_n <= 1'b1;
      end else if (style_q) begin
        wait_ack_out <= iack_ready;
        wait_ack_oe_n <= ~(ack_cyc_q & respond_q);
      end else begin
        wait_ack_out <= ~(rd_act_q | wr_act_q |
                          (ack_cyc_q & respond_q & iack_ready));
        wait_ack_oe_n <= ~slave_busy;
      end
    end
  end

endmodule

/* dv/hbp_host_port_assertions.sv */
// pin-level checks on the host bus port
module hbp_host_port_chk
  import hbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [AD_W-1:0] addr_data_out,
  input wire logic addr_data_oe_n,
  input wire logic cs_n,
  input wire logic rd_n_in,
  input wire logic rd_n_oe_n,
  input wire logic wr_n_out,
  input wire logic wr_n_oe_n,
  input wire logic byte_word_out,
  input wire logic byte_word_oe_n,
  input wire logic wait_ack_in,
  input wire logic wait_ack_out,
  input wire logic wait_ack_oe_n,
  input wire logic hs_style_sel,
  input wire logic irq_req_n,
  input wire logic irq_req_oe_n,
  input wire logic irq_ack_n,
  input wire logic irq_chain_in,
  input wire logic irq_chain_out,
  input wire logic mst_byte,
  input wire logic mst_done,
  input wire logic mst_busy
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_rst_idle;
    $rose(arst_n) |-> addr_data_oe_n && rd_n_oe_n && wr_n_oe_n &&
      byte_word_oe_n && wait_ack_oe_n && irq_req_n && !irq_chain_out;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  property p_mst_own;
    (!rd_n_oe_n || !wr_n_oe_n) |-> mst_busy;
  endproperty
  a_mst_own: assert property (p_mst_own)
    else $error("strobe driven outside master cycle");
  property p_wr_setup;
    !wr_n_oe_n && $fell(wr_n_out) |->
      $past(addr_data_oe_n) == 1'b0 && !addr_data_oe_n;
  endproperty
  a_wr_setup: assert property (p_wr_setup)
    else $error("write data not set up before strobe");
  property p_wr_hold;
    !wr_n_oe_n && $rose(wr_n_out) |->
      !addr_data_oe_n && $stable(addr_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write data not held past strobe");
  property p_bw;
    !byte_word_oe_n |-> byte_word_out == mst_byte;
  endproperty
  a_bw: assert property (p_bw)
    else $error("byte word level wrong");
  property p_wait_hold;
    (hs_style_sel && !wait_ack_in) [*6] |-> !mst_done;
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("master cycle ended during wait");
  property p_ack_hold;
    (!hs_style_sel && wait_ack_in) [*6] |-> !mst_done;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("master cycle ended without ack");
  property p_ack_rd;
    !hs_style_sel && irq_ack_n && !cs_n && rd_n_oe_n && $fell(rd_n_in)
      |-> ##[2:5] (!wait_ack_oe_n && !wait_ack_out);
  endproperty
  a_ack_rd: assert property (p_ack_rd)
    else $error("no ack on register read");
  property p_no_wait;
    hs_style_sel && irq_ack_n && $past(irq_ack_n, 8) |->
      wait_ack_oe_n || wait_ack_out;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("wait asserted on register access");
  property p_rd_hold;
    rd_n_oe_n && $rose(rd_n_in) && !addr_data_oe_n |=> !addr_data_oe_n;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data released at strobe rise");
  property p_req_chain;
    (!irq_chain_in) [*5] |-> irq_req_n || irq_req_oe_n;
  endproperty
  a_req_chain: assert property (p_req_chain)
    else $error("request with chain input low");
  property p_out_chain;
    (!irq_chain_in) [*5] |-> !irq_chain_out;
  endproperty
  a_out_chain: assert property (p_out_chain)
    else $error("chain output high with chain input low");

  c_mst: cover property (mst_done);
  c_iack: cover property (!irq_ack_n && !addr_data_oe_n);
  c_req: cover property (!irq_req_n && !irq_req_oe_n);
endmodule

bind hbp_host_port hbp_host_port_chk u_chk (.*);

/* dv/hbp_mem_model.sv */
// host memory answering master cycles of the port
module hbp_mem_model
  import hbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wait_style,
  input wire logic [3:0] dly,
  input wire logic [AD_W-1:0] ad,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic rd_oe_n,
  input wire logic bw,
  output logic [AD_W-1:0] mem_ad,
  output logic mem_en,
  output logic wait_ack,
  output logic last_bw
);
  logic [AD_W-1:0] mem_q [16];
  logic [AD_W-1:0] addr_q;
  logic [3:0] cnt_q;
  logic own_q;
  logic wr_q;
  logic strb;
  assign strb = !rd_oe_n && !(rd_n && wr_n);
  // released bus shows the inverse word
  assign mem_ad = mem_en ? mem_q[addr_q[3:0]] : ~mem_q[addr_q[3:0]];
  // wait style holds low while slow, ack style drops when ready
  assign wait_ack = wait_style ? !(strb && cnt_q < dly) :
    !(strb && cnt_q >= dly);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      own_q <= 1'b0;
      wr_q <= 1'b1;
      cnt_q <= 4'h0;
      mem_en <= 1'b0;
      last_bw <= 1'b0;
      addr_q <= '0;
    end else begin
      own_q <= !rd_oe_n;
      wr_q <= wr_n;
      mem_en <= strb && !rd_n;
      cnt_q <= !strb ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
      if (!rd_oe_n && !own_q) addr_q <= ad;
      if (strb) last_bw <= bw;
      if (!rd_oe_n && wr_n && !wr_q) mem_q[addr_q[3:0]] <= ad;
    end
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the host bus port
module testbench
  import hbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [AD_W-1:0] host_ad = '0;
  logic host_rd_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic addr_strobe_n = 1'b1;
  logic cs_n = 1'b1;
  logic hs_style_sel = 1'b1;
  logic irq_ack_n = 1'b1;
  logic irq_chain_in = 1'b1;
  logic [7:0] irq_events = '0;
  logic mst_grant = 1'b0;
  logic mst_req = 1'b0;
  logic mst_write = 1'b0;
  logic mst_byte = 1'b0;
  logic [AD_W-1:0] mst_addr = '0;
  logic [AD_W-1:0] mst_wdata = '0;
  logic [3:0] dly = 4'h0;
  logic [AD_W-1:0] v;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic [AD_W-1:0] addr_data_in, addr_data_out, mem_ad, mst_rdata;
  wire logic addr_data_oe_n, rd_n_in, rd_n_out, rd_n_oe_n, wr_n_in;
  wire logic wr_n_out, wr_n_oe_n, byte_word_out, byte_word_oe_n;
  wire logic wait_ack_in, wait_ack_out, wait_ack_oe_n, irq_req_n;
  wire logic irq_req_oe_n, irq_chain_out, mst_done, mem_en, last_bw;
  wire logic irq_pin;

  assign addr_data_in = !addr_data_oe_n ? addr_data_out :
    mem_en ? mem_ad : host_ad;
  assign rd_n_in = rd_n_oe_n ? host_rd_n : rd_n_out;
  assign wr_n_in = wr_n_oe_n ? host_wr_n : wr_n_out;
  // released request pin rises to its pull-up
  assign irq_pin = irq_req_oe_n ? 1'b1 : irq_req_n;

  hbp_host_port uut (.sys_clk, .arst_n, .addr_data_in, .addr_data_out,
    .addr_data_oe_n, .addr_strobe_n, .data_strobe_n(1'b1), .cs_n,
    .rd_n_in, .rd_n_out, .rd_n_oe_n, .wr_n_in, .wr_n_out, .wr_n_oe_n,
    .byte_word_out, .byte_word_oe_n, .wait_ack_in, .wait_ack_out,
    .wait_ack_oe_n, .hs_style_sel, .irq_req_n, .irq_req_oe_n, .irq_ack_n,
    .irq_chain_in, .irq_chain_out, .irq_events, .ext_addr(), .ext_wdata(),
    .ext_wr(), .ext_rd(), .ext_byte(), .ext_rdata(16'hbeef), .mst_grant,
    .mst_req, .mst_write, .mst_byte, .mst_addr, .mst_wdata, .mst_rdata,
    .mst_done, .mst_busy());
  hbp_mem_model mem (.sys_clk, .arst_n, .wait_style(hs_style_sel), .dly,
    .ad(addr_data_in), .rd_n(rd_n_out), .wr_n(wr_n_out),
    .rd_oe_n(rd_n_oe_n), .bw(byte_word_out), .mem_ad, .mem_en,
    .wait_ack(wait_ack_in), .last_bw);

  // ------------------------------------------------------------
  // clock, timeout, tasks
  // ------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(logic [AD_W-1:0] seen, logic [AD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one strobe at a time, each level held four clocks
  task automatic addr_phase(logic [AD_W-1:0] a, logic c);
    cs_n <= c;
    host_ad <= a;
    addr_strobe_n <= 1'b0;
    tick(4);
    addr_strobe_n <= 1'b1;
    tick(4);
  endtask
  task automatic hwrite(logic [AD_W-1:0] a, logic [AD_W-1:0] d, logic c);
    addr_phase(a, c);
    host_ad <= d;
    host_wr_n <= 1'b0;
    tick(4);
    host_wr_n <= 1'b1;
    tick(5);
    cs_n <= 1'b1;
    tick(1);
  endtask
  task automatic hread(input logic [AD_W-1:0] a, output logic [AD_W-1:0] d);
    addr_phase(a, 1'b0);
    host_ad <= ~a;
    host_rd_n <= 1'b0;
    tick(10);
    d = addr_data_in;
    host_rd_n <= 1'b1;
    tick(5);
    cs_n <= 1'b1;
    tick(1);
  endtask
  function automatic logic stb(logic w);
    return w ? wr_n_out : rd_n_out;
  endfunction
  task automatic mcyc(input logic w, input logic b, input logic [AD_W-1:0] a,
    input logic [AD_W-1:0] d, output logic [AD_W-1:0] r);
    int i;
    i = 0;
    mst_write <= w;
    mst_byte <= b;
    mst_addr <= a;
    mst_wdata <= d;
    mst_req <= 1'b1;
    while (stb(w) !== 1'b0 && i++ < 60) tick(1);
    while (stb(w) !== 1'b1 && i++ < 60) tick(1);
    mst_req <= 1'b0;
    while (mst_done !== 1'b1 && i++ < 60) tick(1);
    tick(1);
    r = mst_rdata;
  endtask
  task automatic pulse(logic [7:0] p);
    irq_events <= p;
    tick(1);
    irq_events <= 8'h00;
    tick(5);
  endtask

  // ------------------------------------------------------------
  // tests, wait style then ack style
  // ------------------------------------------------------------
  initial begin
    for (int s = 1; s >= 0; s--) begin
      arst_n <= 1'b0;
      hs_style_sel <= s[0];
      tick(2);
      arst_n <= 1'b1;
      tick(3);
      hwrite(16'h0005, 16'h0004, 1'b0);
      hread(16'h0005, v);
      chk(v, {13'h0, s[0], 2'b11});
      hwrite(16'h0002, 16'h0005, 1'b0);
      hwrite(16'h0002, 16'h00ff, 1'b1);
      hread(16'h0002, v);
      chk(v, 16'h0005);
      hwrite(16'h0004, 16'h1238, 1'b0);
      pulse(8'h04);
      chk(16'({irq_pin, irq_req_oe_n, irq_chain_out}), 16'h0001);
      irq_chain_in <= 1'b0;
      tick(6);
      chk(16'({irq_pin, irq_req_oe_n, irq_chain_out}), 16'h0006);
      irq_chain_in <= 1'b1;
      tick(6);
      irq_ack_n <= 1'b0;
      hread(16'h0005, v);
      irq_ack_n <= 1'b1;
      chk(v, 16'h123a);
      tick(4);
      chk(16'({irq_pin, irq_chain_out}), 16'h0002);
      pulse(8'h01);
      chk(16'({irq_pin, irq_chain_out}), 16'h0000);
      hwrite(16'h0003, 16'h0004, 1'b0);
      hwrite(16'h0001, 16'h0005, 1'b0);
      chk(16'({irq_pin, irq_chain_out}), 16'h0003);
      hwrite(16'h0000, 16'h0000, 1'b0);
      chk(16'({irq_req_n, irq_req_oe_n}), 16'h0002);
      pulse(8'h01);
      chk(16'({irq_req_n, irq_req_oe_n}), 16'h0000);
      hread(16'h0006, v);
      chk(v, 16'hbeef);
      mst_grant <= 1'b1;
      dly <= 4'h0;
      mcyc(1'b1, 1'b1, 16'h0003, s ? 16'ha55a : 16'h5aa5, v);
      chk(16'(last_bw), 16'h0001);
      dly <= 4'h8;
      mcyc(1'b0, 1'b0, 16'h0003, 16'h0000, v);
      chk(v, s ? 16'ha55a : 16'h5aa5);
      chk(16'(last_bw), 16'h0000);
      mst_grant <= 1'b0;
      tick(2);
    end
    complete_run();
  end
endmodule
